// >>> acsw_ctrl.sv
// Purpose: Backplane register bank and eight channel drivers.
// Assumes: Bus strobes are one-cycle pulses synchronous to clk.
// Notes: Read data is registered, valid the cycle after the strobe.
`timescale 1ns/100ps
`include "acsw_cfg.svh"
module acsw_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic term_present,
  input wire logic [2:0] term_type,
  input wire logic vzero_in,
  input wire logic izero_in,
  output logic [7:0] scr_gate,
  output logic [7:0] relay_coil
);
  import acsw_pkg::*;

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  logic sel_ident;
  logic sel_const;
  logic sel_state;
  logic wr_reset;
  logic wr_command;
  logic rd_ident;
  logic rd_const;
  logic rd_state;
  logic clear_all;

  assign sel_ident = (bus_addr == `ACSW_REG_IDENT);
  assign sel_const = (bus_addr == `ACSW_REG_CONST);
  assign sel_state = (bus_addr == `ACSW_REG_STATE_A) ||
                     (bus_addr == `ACSW_REG_STATE_B);
  assign wr_reset = bus_wr && sel_ident;
  assign wr_command = bus_wr && sel_state;
  assign rd_ident = bus_rd && sel_ident;
  assign rd_const = bus_rd && sel_const;
  assign rd_state = bus_rd && sel_state;
  // Writes to the constant register match no write term and are lost.
  assign clear_all = !reset_n || wr_reset;

  // -------------------------------------------------------------
  // Zero crossing synchronisers
  // -------------------------------------------------------------
  logic vz_meta_reg;
  logic vz_sync_reg;
  logic vz_last_reg;
  logic iz_meta_reg;
  logic iz_sync_reg;
  logic iz_last_reg;
  logic vpos_edge;
  logic vneg_edge;
  logic izero_edge;

  // The chains run through reset, so a line that is already high when
  // reset ends never shows a false edge.
  always_ff @(posedge clk) begin
    vz_meta_reg <= vzero_in;
  end

  always_ff @(posedge clk) begin
    vz_sync_reg <= vz_meta_reg;
  end

  always_ff @(posedge clk) begin
    vz_last_reg <= vz_sync_reg;
  end

  always_ff @(posedge clk) begin
    iz_meta_reg <= izero_in;
  end

  always_ff @(posedge clk) begin
    iz_sync_reg <= iz_meta_reg;
  end

  always_ff @(posedge clk) begin
    iz_last_reg <= iz_sync_reg;
  end

  // Voltage polarity high means the line is positive.
  assign vpos_edge = vz_sync_reg && !vz_last_reg;
  assign vneg_edge = !vz_sync_reg && vz_last_reg;
  assign izero_edge = iz_sync_reg && !iz_last_reg;

  // -------------------------------------------------------------
  // Line phase pulses
  // -------------------------------------------------------------
  // Registered pulses keep the eight-way fan-out off the edge logic.
  logic vpos_pulse_reg;
  logic vneg_pulse_reg;
  logic izero_pulse_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vpos_pulse_reg <= 1'b0;
    end else begin
      vpos_pulse_reg <= vpos_edge;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vneg_pulse_reg <= 1'b0;
    end else begin
      vneg_pulse_reg <= vneg_edge;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      izero_pulse_reg <= 1'b0;
    end else begin
      izero_pulse_reg <= izero_edge;
    end
  end

  // -------------------------------------------------------------
  // Command register
  // -------------------------------------------------------------
  logic card_reset;
  logic [7:0] command_reg;

  assign card_reset = wr_reset;

  always_ff @(posedge clk) begin
    if (clear_all) begin
      command_reg <= `ACSW_CMD_RESET;
    end else if (wr_command) begin
      command_reg <= bus_wdata[7:0];
    end
  end

  // -------------------------------------------------------------
  // Status register
  // -------------------------------------------------------------
  // Status mirrors the command, not the sensed contacts; a copy keeps
  // the read path apart from the channel fan-out.
  logic [7:0] status_reg;

  genvar sb;
  generate
    for (sb = 0; sb < 8; sb = sb + 1) begin : g_stat
      always_ff @(posedge clk) begin
        if (clear_all) begin
          status_reg[sb] <= 1'b0;
        end else if (wr_command) begin
          status_reg[sb] <= bus_wdata[sb];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------
  logic [7:0] ident;
  logic [2:0] term_bits;
  logic [15:0] rdata_next;

  always_comb begin
    if (term_present) begin
      term_bits = term_type;
    end else begin
      term_bits = `ACSW_NO_TERM;
    end
  end

  assign ident = {`ACSW_CARD_CODE, term_bits};

  // Read data holds between reads, so a slow host may take it late.
  always_comb begin
    rdata_next = bus_rdata;
    if (rd_ident) begin
      rdata_next = {8'h00, ident};
    end else if (rd_const) begin
      rdata_next = `ACSW_CONST_VALUE;
    end else if (rd_state) begin
      rdata_next = {8'h00, status_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= rdata_next;
    end
  end

  // -------------------------------------------------------------
  // Channel drivers
  // -------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_chan
      acsw_channel u_chan (
        .clk(clk),
        .reset_n(reset_n),
        .clr(card_reset),
        .cmd_close(command_reg[ch]),
        .vpos_edge(vpos_pulse_reg),
        .vneg_edge(vneg_pulse_reg),
        .izero_edge(izero_pulse_reg),
        .gate(scr_gate[ch]),
        .coil(relay_coil[ch])
      );
    end
  endgenerate
endmodule : acsw_ctrl

// >>> acsw_cfg.svh
// Purpose: Constants for the eight-channel AC switch control logic.
// Assumes: Register index on a short address bus, 16-bit data bus.
// Notes: Identity component code is arbitrary.
//
// Summary of operation
// - Reading identity register drives eight-bit identity on low data lines.
// - Upper five identity bits give card type, lower three terminal type.
// - Missing terminal module forces the three low identity bits high.
// - Register one always reads decimal -240.
// - Read registers two and three return the same status word.
// - Status word shows last commanded channel states, not sensed contacts.
// - Status bit n is channel n; one means commanded closed.
// - Any write to register zero resets card and opens all channels.
// - Opening after reset may wait for next current zero crossing.
// - Reset register write acts as the backplane reset on command, status and channels; read data holds.
// - Write registers two and three both load the command word.
// - Command bit n set closes channel n, clear opens it.
// - Each channel drives a thyristor gate line and a relay coil line.
// - Closing follows AC line phase; on open the coil drops two clocks after the command register loads.
// - On close, thyristor gate is asserted before the relay coil.
// - Closing gate asserts at a positive-going voltage zero crossing.
// - Gate releases at the next negative-going voltage zero crossing.
// - On open, gate reasserts on the same clock edge as the relay coil drops.
// - Opening completes at a current zero crossing.
`ifndef ACSW_CFG_SVH
`define ACSW_CFG_SVH
`define ACSW_REG_IDENT 2'h0
`define ACSW_REG_CONST 2'h1
`define ACSW_REG_STATE_A 2'h2
`define ACSW_REG_STATE_B 2'h3
`define ACSW_CONST_VALUE 16'hFF10
`define ACSW_CARD_CODE 5'h15
`define ACSW_NO_TERM 3'h7
`define ACSW_CMD_RESET 8'h00
`endif

// >>> acsw_pkg.sv
// Purpose: Types for the AC switch control logic.
// Assumes: Nothing beyond the constants header.
// Notes: Channel sequencer states.
package acsw_pkg;
  typedef enum logic [2:0] {
    ACSW_OPEN = 3'b000,
    ACSW_WAIT_POS = 3'b001,
    ACSW_GATE_ON = 3'b010,
    ACSW_CLOSED = 3'b011,
    ACSW_GATE_OFF = 3'b100
  } acsw_state_t;
endpackage : acsw_pkg

// >>> acsw_channel.sv
// Purpose: One channel sequencer for thyristor gate and relay coil.
// Assumes: Edge pulses are one clock wide and already synchronised.
// Notes: Relay energises one cycle after the gate at the positive edge.
`timescale 1ns/100ps
module acsw_channel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clr,
  input wire logic cmd_close,
  input wire logic vpos_edge,
  input wire logic vneg_edge,
  input wire logic izero_edge,
  output logic gate,
  output logic coil
);
  import acsw_pkg::*;

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  acsw_state_t state_reg;
  acsw_state_t state_next;
  acsw_state_t state_clr;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACSW_OPEN: begin
        if (cmd_close) begin
          state_next = ACSW_WAIT_POS;
        end
      end
      ACSW_WAIT_POS: begin
        if (!cmd_close) begin
          state_next = ACSW_OPEN;
        end else if (vpos_edge) begin
          state_next = ACSW_GATE_ON;
        end
      end
      ACSW_GATE_ON: begin
        if (!cmd_close) begin
          state_next = ACSW_GATE_OFF;
        end else if (vneg_edge) begin
          state_next = ACSW_CLOSED;
        end
      end
      ACSW_CLOSED: begin
        if (!cmd_close) begin
          state_next = ACSW_GATE_OFF;
        end
      end
      ACSW_GATE_OFF: begin
        if (cmd_close) begin
          state_next = ACSW_GATE_ON;
        end else if (izero_edge) begin
          state_next = ACSW_OPEN;
        end
      end
      default: begin
        state_next = ACSW_OPEN;
      end
    endcase
  end

  // A reset clears the command and sends an active channel to ACSW_GATE_OFF; it still ends at a
  // current zero, so contacts never part under load. An unknown
  // state falls to open, so power-up settles in one reset edge.
  always_comb begin
    case (state_reg)
      ACSW_GATE_ON, ACSW_CLOSED, ACSW_GATE_OFF: begin
        state_clr = ACSW_GATE_OFF;
      end
      default: begin
        state_clr = ACSW_OPEN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n || clr) begin
      state_reg <= state_clr;
    end else begin
      state_reg <= state_next;
    end
  end

  // Gate leads the coil on close; coil drops on or after the edge that asserts the gate.
  // Both resets act alike, so the gate carries the current at once.
  always_ff @(posedge clk) begin
    if (!reset_n || clr) begin
      gate <= (state_clr == ACSW_GATE_OFF);
      coil <= 1'b0;
    end else begin
      gate <= (state_reg == ACSW_GATE_ON) || (state_reg == ACSW_GATE_OFF);
      coil <= ((state_reg == ACSW_GATE_ON) && gate) ||
              (state_reg == ACSW_CLOSED);
    end
  end
endmodule : acsw_channel

// >>> acsw_line.sv
// Purpose: AC line model feeding the zero-crossing inputs.
// Assumes: Resistive load, current zero just ahead of voltage zero.
// Notes: Edges fall on falling clock edges, between rising edges.
`timescale 1ns/100ps
module acsw_line #(
  parameter int HALF_NS = 500
) (
  output logic vzero_in,
  output logic izero_in
);
  initial begin
    vzero_in = 1'b0;
    izero_in = 1'b0;
    forever begin
      #(HALF_NS - 30) izero_in = 1'b1;
      #30 izero_in = 1'b0;
      vzero_in = ~vzero_in;
    end
  end
endmodule : acsw_line

// >>> acsw_ctrl_properties.sv
// Purpose: Port checks for acsw_ctrl.
// Assumes: Strobes one cycle wide.
// Notes: Channel 0 stands for the sequencing of all eight.
`timescale 1ns/100ps
`include "acsw_cfg.svh"
module acsw_ctrl_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic term_present,
  input wire logic vzero_in,
  input wire logic [7:0] scr_gate,
  input wire logic [7:0] relay_coil
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_cmd;
    bus_wr && bus_addr[1];
  endsequence
  sequence s_stat;
    bus_rd && bus_addr[1];
  endsequence
  property p_const;
    bus_rd && bus_addr == 2'h1 |=> bus_rdata == 16'hFF10;
  endproperty
  property p_noterm;
    bus_rd && bus_addr == 2'h0 && !term_present |=> bus_rdata[2:0] == 3'h7;
  endproperty
  property p_stat;
    s_cmd ##1 (!bus_wr)[*2] ##1 s_stat |=>
      bus_rdata == {8'h00, $past(bus_wdata[7:0], 4)};
  endproperty
  property p_rst;
    bus_wr && bus_addr == 2'h0 |-> ##[1:4] relay_coil == 8'h00;
  endproperty
  property p_order;
    ((relay_coil & ~$past(relay_coil)) & ~$past(scr_gate)) == 8'h00;
  endproperty
  property p_close;
    $rose(relay_coil[0]) |-> vzero_in;
  endproperty
  property p_release;
    $fell(scr_gate[0]) && relay_coil[0] |-> !vzero_in;
  endproperty
  property p_open;
    $fell(relay_coil[0]) |-> scr_gate[0];
  endproperty
  a_const: assert property (p_const) else $error("bad const");
  a_noterm: assert property (p_noterm) else $error("bad id");
  a_stat: assert property (p_stat) else $error("bad status");
  a_rst: assert property (p_rst) else $error("no reset");
  a_order: assert property (p_order) else $error("coil early");
  a_close: assert property (p_close) else $error("bad close");
  a_release: assert property (p_release) else $error("bad release");
  a_open: assert property (p_open) else $error("bad open");
endmodule : acsw_ctrl_properties
bind acsw_ctrl acsw_ctrl_properties u_acsw_ctrl_properties (.clk(clk),
  .reset_n(reset_n), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .term_present(term_present),
  .vzero_in(vzero_in), .scr_gate(scr_gate), .relay_coil(relay_coil));

// >>> tb.sv
// Purpose: Self-checking bench for acsw_ctrl.
// Assumes: acsw_line gives a 1 us line period.
// Notes: Waits are bounded by a poll count.
`timescale 1ns/100ps
`include "acsw_cfg.svh"
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] bus_addr = 2'h0;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata;
  logic term_present = 1'b1;
  logic [2:0] term_type = 3'h0;
  logic vzero_in;
  logic izero_in;
  logic [7:0] scr_gate;
  logic [7:0] relay_coil;
  logic [15:0] rd;
  int fails = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  acsw_line u_acsw_line (.vzero_in(vzero_in), .izero_in(izero_in));
  acsw_ctrl u_acsw_ctrl (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .term_present(term_present),
    .term_type(term_type), .vzero_in(vzero_in), .izero_in(izero_in),
    .scr_gate(scr_gate), .relay_coil(relay_coil));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_op(input logic wr, input logic [1:0] a,
    input logic [15:0] d);
    @(posedge clk) #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = wr;
    bus_rd = !wr;
    @(posedge clk) #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    @(posedge clk) #1;
    rd = bus_rdata;
  endtask : bus_op
  task automatic wait_drv(input logic [7:0] g, input logic [7:0] c);
    int n;
    n = 0;
    while ((scr_gate !== g || relay_coil !== c) && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    check({scr_gate, relay_coil}, {g, c});
  endtask : wait_drv
  task automatic t_ident();
    for (int t = 0; t < 8; t++) begin
      term_type = 3'(t);
      bus_op(1'b0, 2'h0, 16'h0000);
      check(rd, {8'h00, `ACSW_CARD_CODE, 3'(t)});
    end
    term_present = 1'b0;
    bus_op(1'b0, 2'h0, 16'h0000);
    check(rd, {8'h00, `ACSW_CARD_CODE, 3'h7});
    term_present = 1'b1;
  endtask : t_ident
  task automatic t_switch();
    bus_op(1'b1, 2'h2, 16'h0081);
    wait_drv(8'h81, 8'h00);
    wait_drv(8'h81, 8'h81);
    bus_op(1'b0, 2'h3, 16'h0000);
    check(rd, 16'h0081);
    wait_drv(8'h00, 8'h81);
    bus_op(1'b1, 2'h1, 16'h00FF);
    bus_op(1'b0, 2'h1, 16'h0000);
    check(rd, 16'hFF10);
    bus_op(1'b1, 2'h3, 16'h0000);
    wait_drv(8'h81, 8'h00);
    wait_drv(8'h00, 8'h00);
    bus_op(1'b0, 2'h2, 16'h0000);
    check(rd, 16'h0000);
  endtask : t_switch
  task automatic t_reset();
    bus_op(1'b1, 2'h2, 16'h00FF);
    wait_drv(8'hFF, 8'hFF);
    bus_op(1'b1, 2'h0, 16'h005A);
    bus_op(1'b0, 2'h3, 16'h0000);
    check(rd, 16'h0000);
    wait_drv(8'h00, 8'h00);
    bus_op(1'b1, 2'h3, 16'h000F);
    bus_op(1'b0, 2'h2, 16'h0000);
    check(rd, 16'h000F);
    wait_drv(8'h0F, 8'h0F);
    reset_n = 1'b0;
    @(posedge clk) #1;
    reset_n = 1'b1;
    bus_op(1'b0, 2'h2, 16'h0000);
    check(rd, 16'h0000);
    wait_drv(8'h00, 8'h00);
  endtask : t_reset
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    t_ident();
    t_switch();
    t_reset();
    conclude();
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule : tb
